// [core/dnc_config.v]
// Function
// - Q select bit 2: 0 first channel of pair, 1 second channel.
// - I select bit 0: 0 channel A, 1 channel B to in-phase path.
// - Accumulator adds frequency word once per sample; f = word*fs/2^48.
// - 48-bit signed phase offset bytes 0x31d..0x322 added to phase.
// - Q test bit 2 replaces Q samples by second test generator.
// - I test bit 0 replaces I samples by first test generator.
//
// Configuration slice of the first downconverter: register port, channel
// selection, oscillator phase and test-pattern routing.
// Assumes sample inputs and the sample enable are on clk; the register
// port is driven by a master on the same clock.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "dnc_regs.vh"
module dnc_config #(
	parameter DATA_W = 14,
	parameter PHASE_W = `DNC_PHASE_W
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register port
	input wire [`DNC_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Sample inputs
	input wire sample_en,
	input wire [DATA_W-1:0] chan_a,
	input wire [DATA_W-1:0] chan_b,
	input wire [DATA_W-1:0] chan_c,
	input wire [DATA_W-1:0] chan_d,
	input wire [DATA_W-1:0] test_pattern_i,
	input wire [DATA_W-1:0] test_pattern_q,
	// Downconverter feeds
	output wire [DATA_W-1:0] i_data,
	output wire [DATA_W-1:0] q_data,
	output wire [PHASE_W-1:0] nco_phase,
	// Configuration view for neighbouring sections
	output reg i_sel,
	output reg q_sel,
	output reg i_test_en,
	output reg q_test_en,
	output reg [PHASE_W-1:0] freq_word,
	output reg [PHASE_W-1:0] phase_offset
);
	reg [7:0] next_rdata;

	// Places one byte into a 48-bit word at byte lane idx.
	function [47:0] put_byte;
		input [47:0] word;
		input [2:0] idx;
		input [7:0] data;
		reg [47:0] mask;
		begin
			mask = 48'h0000000000ff << {idx, 3'b000};
			put_byte = (word & ~mask) | ({40'h0000000000, data} << {idx, 3'b000});
		end
	endfunction

	// Byte lane of an address within a six-byte group, 3'h7 when outside.
	function [2:0] freq_lane;
		input [`DNC_ADDR_W-1:0] a;
		begin
			if (a == `DNC_FREQ_B0_ADDR) freq_lane = 3'h0;
			else if (a == `DNC_FREQ_B1_ADDR) freq_lane = 3'h1;
			else if (a == `DNC_FREQ_B2_ADDR) freq_lane = 3'h2;
			else if (a == `DNC_FREQ_B3_ADDR) freq_lane = 3'h3;
			else if (a == `DNC_FREQ_B4_ADDR) freq_lane = 3'h4;
			else if (a == `DNC_FREQ_B5_ADDR) freq_lane = 3'h5;
			else freq_lane = 3'h7;
		end
	endfunction

	function [2:0] phofs_lane;
		input [`DNC_ADDR_W-1:0] a;
		begin
			if (a == `DNC_PHOFS_B0_ADDR) phofs_lane = 3'h0;
			else if (a == `DNC_PHOFS_B1_ADDR) phofs_lane = 3'h1;
			else if (a == `DNC_PHOFS_B2_ADDR) phofs_lane = 3'h2;
			else if (a == `DNC_PHOFS_B3_ADDR) phofs_lane = 3'h3;
			else if (a == `DNC_PHOFS_B4_ADDR) phofs_lane = 3'h4;
			else if (a == `DNC_PHOFS_B5_ADDR) phofs_lane = 3'h5;
			else phofs_lane = 3'h7;
		end
	endfunction

	wire [2:0] wr_freq_lane = freq_lane(reg_addr);
	wire [2:0] wr_phofs_lane = phofs_lane(reg_addr);

	// Only defined bits are stored, so reserved bits can never read back.
	always @(posedge clk) begin
		if (rst) begin
			i_sel <= 1'b0;
			q_sel <= 1'b0;
			i_test_en <= 1'b0;
			q_test_en <= 1'b0;
			freq_word <= `DNC_WORD_RESET;
			phase_offset <= `DNC_WORD_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `DNC_CHSEL_ADDR) begin
				i_sel <= reg_wdata[`DNC_I_SEL_BIT];
				q_sel <= reg_wdata[`DNC_Q_SEL_BIT];
			end else if (reg_addr == `DNC_TEST_ADDR) begin
				i_test_en <= reg_wdata[`DNC_I_TEST_BIT];
				q_test_en <= reg_wdata[`DNC_Q_TEST_BIT];
			end else if (wr_freq_lane != 3'h7) begin
				freq_word <= put_byte(freq_word, wr_freq_lane, reg_wdata);
			end else if (wr_phofs_lane != 3'h7) begin
				phase_offset <= put_byte(phase_offset, wr_phofs_lane,
					reg_wdata);
			end
		end
	end

	// Read mux; unmapped addresses and reserved bits answer zero.
	always @* begin
		next_rdata = 8'h00;
		if (reg_addr == `DNC_CHSEL_ADDR) begin
			next_rdata[`DNC_I_SEL_BIT] = i_sel;
			next_rdata[`DNC_Q_SEL_BIT] = q_sel;
		end else if (reg_addr == `DNC_TEST_ADDR) begin
			next_rdata[`DNC_I_TEST_BIT] = i_test_en;
			next_rdata[`DNC_Q_TEST_BIT] = q_test_en;
		end else if (wr_freq_lane != 3'h7) begin
			next_rdata = freq_word[{wr_freq_lane, 3'b000} +: 8];
		end else if (wr_phofs_lane != 3'h7) begin
			next_rdata = phase_offset[{wr_phofs_lane, 3'b000} +: 8];
		end
	end

	// Read data stand only in the cycle after the strobe.
	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// The in-phase path picks A or B; the quadrature path picks within
	// the pair as well. Which pair the Q path belongs to is fixed here to
	// A/B; the C/D pair is served by the other downconverter.
	dnc_path_mux #(
		.DATA_W(DATA_W)
	) u_i_mux (
		.clk(clk),
		.rst(rst),
		.chan_sel(i_sel),
		.test_en(i_test_en),
		.chan_first(chan_a),
		.chan_second(chan_b),
		.test_data(test_pattern_i),
		.data_out(i_data)
	);

	dnc_path_mux #(
		.DATA_W(DATA_W)
	) u_q_mux (
		.clk(clk),
		.rst(rst),
		.chan_sel(q_sel),
		.test_en(q_test_en),
		.chan_first(chan_a),
		.chan_second(chan_b),
		.test_data(test_pattern_q),
		.data_out(q_data)
	);

	dnc_nco #(
		.PHASE_W(PHASE_W)
	) u_nco (
		.clk(clk),
		.rst(rst),
		.sample_en(sample_en),
		.freq_word(freq_word),
		.phase_offset(phase_offset),
		.phase(nco_phase)
	);

	// Unused C/D inputs are kept on the port so the pair wiring matches
	// the other downconverter; they do not steer anything here.
	wire unused_cd = ^{chan_c, chan_d};
endmodule // dnc_config
`default_nettype wire

// [core/dnc_nco.v]
// Phase accumulator of the oscillator: adds the frequency word on each
// sample enable and presents accumulated phase plus offset.
// Assumes a synchronous active-high reset and a one-cycle sample enable.
`timescale 1ns/100ps
`default_nettype none
module dnc_nco #(
	parameter PHASE_W = 48
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Control
	input wire sample_en,
	input wire [PHASE_W-1:0] freq_word,
	input wire [PHASE_W-1:0] phase_offset,
	// Phase out
	output reg [PHASE_W-1:0] phase
);
	reg [PHASE_W-1:0] accum;

	// Wrapping modulo 2^48 gives f = word * fs / 2^48; negative words
	// simply run the phase backwards.
	always @(posedge clk) begin
		if (rst) begin
			accum <= {PHASE_W{1'b0}};
			phase <= {PHASE_W{1'b0}};
		end else if (sample_en) begin
			accum <= accum + freq_word;
			phase <= accum + phase_offset;
		end
	end
endmodule // dnc_nco
`default_nettype wire

// [core/dnc_path_mux.v]
// Selects one sample path: a choice between two channels, then an
// optional replacement by a test pattern. Registered output.
// Assumes all inputs are on clk.
`timescale 1ns/100ps
`default_nettype none
module dnc_path_mux #(
	parameter DATA_W = 14
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Controls
	input wire chan_sel,
	input wire test_en,
	// Samples
	input wire [DATA_W-1:0] chan_first,
	input wire [DATA_W-1:0] chan_second,
	input wire [DATA_W-1:0] test_data,
	output reg [DATA_W-1:0] data_out
);
	always @(posedge clk) begin
		if (rst) begin
			data_out <= {DATA_W{1'b0}};
		end else if (test_en) begin
			data_out <= test_data;
		end else if (chan_sel) begin
			data_out <= chan_second;
		end else begin
			data_out <= chan_first;
		end
	end
endmodule // dnc_path_mux
`default_nettype wire

// [inc/dnc_regs.vh]
// Register map, field positions and reset values of the downconverter
// configuration slice. Included by the core files; holds definitions only.
`ifndef DNC_REGS_VH
`define DNC_REGS_VH

`define DNC_ADDR_W 12
`define DNC_CHSEL_ADDR 12'h311
`define DNC_FREQ_B0_ADDR 12'h314
`define DNC_FREQ_B1_ADDR 12'h315
`define DNC_FREQ_B2_ADDR 12'h316
`define DNC_FREQ_B3_ADDR 12'h317
`define DNC_FREQ_B4_ADDR 12'h318
`define DNC_FREQ_B5_ADDR 12'h31a
`define DNC_PHOFS_B0_ADDR 12'h31d
`define DNC_PHOFS_B1_ADDR 12'h31e
`define DNC_PHOFS_B2_ADDR 12'h31f
`define DNC_PHOFS_B3_ADDR 12'h320
`define DNC_PHOFS_B4_ADDR 12'h321
`define DNC_PHOFS_B5_ADDR 12'h322
`define DNC_TEST_ADDR 12'h327

`define DNC_I_SEL_BIT 0
`define DNC_Q_SEL_BIT 2
`define DNC_I_TEST_BIT 0
`define DNC_Q_TEST_BIT 2

`define DNC_BYTE_RESET 8'h00
`define DNC_WORD_RESET 48'h000000000000
`define DNC_PHASE_W 48

`endif

// [tb/dnc_config_sva.sv]
// Concurrent checks on the ports of the downconverter configuration slice.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dnc_config_sva #(
	parameter DATA_W = 14,
	parameter PHASE_W = 48
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Samples
	input wire logic sample_en,
	input wire logic [DATA_W-1:0] chan_a,
	input wire logic [DATA_W-1:0] chan_b,
	input wire logic [DATA_W-1:0] test_pattern_i,
	input wire logic [DATA_W-1:0] test_pattern_q,
	input wire logic [DATA_W-1:0] i_data,
	input wire logic [DATA_W-1:0] q_data,
	input wire logic [PHASE_W-1:0] nco_phase,
	// Configuration view
	input wire logic i_sel,
	input wire logic q_sel,
	input wire logic i_test_en,
	input wire logic q_test_en,
	input wire logic [PHASE_W-1:0] freq_word,
	input wire logic [PHASE_W-1:0] phase_offset
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_two_steps;
		!rst && sample_en ##1 sample_en;
	endsequence
	a_i_path: assert property (
		!$past(rst) |-> i_data == $past(i_test_en ? test_pattern_i :
		(i_sel ? chan_b : chan_a)))
		else $error("in-phase sample mismatch");
	a_q_path: assert property (
		!$past(rst) |-> q_data == $past(q_test_en ? test_pattern_q :
		(q_sel ? chan_b : chan_a)))
		else $error("quadrature sample mismatch");
	a_phase_hold: assert property (
		!$past(rst) && !$past(sample_en) |-> $stable(nco_phase))
		else $error("phase moved without a sample");
	a_phase_step: assert property (
		s_two_steps |=> nco_phase - $past(nco_phase) ==
		$past(freq_word, 2) + $past(phase_offset) - $past(phase_offset, 2))
		else $error("phase step wrong");
	a_freq_top: assert property (
		$past(reg_wr) && !$past(rst) && $past(reg_addr) == 12'h31a
		|-> freq_word[47:40] == $past(reg_wdata))
		else $error("frequency top byte not written");
	a_offs_low: assert property (
		$past(reg_wr) && !$past(rst) && $past(reg_addr) == 12'h31d
		|-> phase_offset[7:0] == $past(reg_wdata))
		else $error("offset low byte not written");
	a_sel_read: assert property (
		$past(reg_rd) && !$past(rst) && $past(reg_addr) == 12'h311
		|-> reg_rdata == {5'h00, $past(q_sel), 1'b0, $past(i_sel)})
		else $error("select register read wrong");
	a_test_read: assert property (
		$past(reg_rd) && !$past(rst) && $past(reg_addr) == 12'h327
		|-> reg_rdata == {5'h00, $past(q_test_en), 1'b0, $past(i_test_en)})
		else $error("test register read wrong");
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
endmodule // dnc_config_sva
bind dnc_config dnc_config_sva #(
	.DATA_W(DATA_W),
	.PHASE_W(PHASE_W)
) u_sva (
	.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.sample_en, .chan_a, .chan_b, .test_pattern_i, .test_pattern_q,
	.i_data, .q_data, .nco_phase, .i_sel, .q_sel, .i_test_en,
	.q_test_en, .freq_word, .phase_offset
);
`default_nettype wire

// [tb/dnc_src.sv]
// Behavioural source of converter samples and of the sample enable.
// Assumes a synchronous active-high reset on the slice's clock.
`timescale 1ns/100ps
`default_nettype none
module dnc_src (
	// Clock, reset and pacing
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	// Samples
	output logic sample_en,
	output logic [13:0] ca,
	output logic [13:0] cb,
	output logic [13:0] tpi,
	output logic [13:0] tpq
);
	logic [13:0] n;
	logic [1:0] d;
	always_ff @(posedge clk) begin
		n <= rst ? 14'h0000 : n + 14'h0001;
		d <= (rst || d == 2'h2) ? 2'h0 : d + 2'h1;
	end
	// Every sample source moves each cycle so that a stale or misrouted sample shows.
	assign sample_en = !rst && (!slow || d == 2'h0);
	assign ca = n;
	assign cb = ~n;
	assign tpi = n ^ 14'h1555;
	assign tpq = n + 14'h0a5a;
endmodule // dnc_src
`default_nettype wire

// [tb/test_ddc_input_nco_config.sv]
// Self-checking bench of the downconverter configuration slice.
// Assumes the sample source model and the checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module test_ddc_input_nco_config;
	logic clk = 0, rst = 1, wr = 0, rd = 0, slow = 0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wd = 8'h00, rdata;
	logic se, is, qs, it, qt;
	logic [13:0] ca, cb, tpi, tpq, i_d, q_d, ei, eq;
	logic [47:0] ph, fw, po, p;
	logic [3:0] cfg = 4'h0;
	logic [11:0] ad [14] = '{12'h311, 12'h314, 12'h315, 12'h316, 12'h317,
		12'h318, 12'h31a, 12'h31d, 12'h31e, 12'h31f, 12'h320, 12'h321,
		12'h322, 12'h327};
	int n_errors = 0, n_tests = 0;
	always #25 clk = ~clk;
	dnc_src src (.clk(clk), .rst(rst), .slow(slow), .sample_en(se),
		.ca(ca), .cb(cb), .tpi(tpi), .tpq(tpq));
	dnc_config dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .sample_en(se),
		.chan_a(ca), .chan_b(cb), .chan_c(14'h0000), .chan_d(14'h0000),
		.test_pattern_i(tpi), .test_pattern_q(tpq), .i_data(i_d),
		.q_data(q_d), .nco_phase(ph), .i_sel(is), .q_sel(qs),
		.i_test_en(it), .q_test_en(qt), .freq_word(fw), .phase_offset(po));
	// Reference of the routed samples, one cycle behind the sources.
	always @(posedge clk) begin
		ei <= cfg[2] ? tpi : cfg[0] ? cb : ca;
		eq <= cfg[3] ? tpq : cfg[1] ? cb : ca;
	end
	task chk(input string nm, input logic [47:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("reg_rdata", {40'h0, rdata}, {40'h0, e});
	endtask
	task close_out;
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		close_out;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 14; i++) rd_reg(ad[i], 8'h00);
		chk("nco_phase", ph, 48'h0);
		for (int i = 0; i < 14; i++)
			wr_reg(ad[i], (i % 13) ? 8'(8'h80 + i) : 8'hff);
		wr_reg(12'h319, 8'hff);
		for (int i = 0; i < 14; i++)
			rd_reg(ad[i], (i % 13) ? 8'(8'h80 + i) : 8'h05);
		rd_reg(12'h319, 8'h00);
		chk("freq_word", fw, 48'h868584838281);
		chk("phase_offset", po, 48'h8c8b8a898887);
		@(negedge clk);
		p = ph;
		@(negedge clk);
		chk("nco_step", ph - p, 48'h868584838281);
		@(posedge clk) slow <= 1'b1;
		repeat (3) @(negedge clk);
		p = ph;
		repeat (3) @(negedge clk);
		chk("nco_slow_step", ph - p, 48'h868584838281);
		for (int k = 0; k < 16; k++) begin
			wr_reg(12'h311, {5'h00, k[1], 1'b0, k[0]});
			wr_reg(12'h327, {5'h00, k[3], 1'b0, k[2]});
			cfg = 4'(k);
			repeat (2) @(negedge clk);
			chk("sel_bits", 48'({qs, is}), 48'(cfg[1:0]));
			chk("test_bits", 48'({qt, it}), 48'(cfg[3:2]));
			chk("i_data", {34'h0, i_d}, {34'h0, ei});
			chk("q_data", {34'h0, q_d}, {34'h0, eq});
		end
		// A reset in mid-run must clear every field that was set above.
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_reg(12'h311, 8'h00);
		rd_reg(12'h327, 8'h00);
		chk("cfg_reset", 48'({qt, it, qs, is}), 48'h0);
		chk("freq_reset", fw, 48'h0);
		chk("offset_reset", po, 48'h0);
		chk("phase_reset", ph, 48'h0);
		close_out;
	end
endmodule // test_ddc_input_nco_config
`default_nettype wire
